// ===== core/vram_ctl.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Controller for the serial port of a dual-port video memory.
module vram_ctl #(
	parameter int PWRUP_CYCLES = vram_ctl_pkg::PWRUP_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Memory strobes and address
	output logic             row_strobe_n,
	output logic             column_strobe_n,
	output logic             write_strobe_n,
	output logic             transfer_select_n,
	output logic             special_function_select,
	output logic      [8:0]  addr,
	// Serial port
	output logic             serial_shift_clock,
	output logic             serial_output_enable_n,
	input  wire logic        half_indicator_out
);
	typedef enum logic [2:0] {C_PWR, C_INITROW, C_INITXF, C_INITSC, C_IDLE, C_CYC, C_SC}
		ctl_e;

	ctl_e        st_ff, nxt_st;
	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [31:0] addr_reg_ff, nxt_addr_reg;
	logic [15:0] shift_ff, nxt_shift;
	logic [15:0] wait_ff, nxt_wait;
	logic        stopm_ff, nxt_stopm;
	logic        fulld_ff, nxt_fulld;
	logic        err_ff, nxt_err;
	logic        initd_ff, nxt_initd;
	logic [2:0]  cmd_ff, nxt_cmd;
	logic [8:0]  addr_ff, nxt_addr;
	logic        trg_ff, nxt_trg;
	logic        we_ff, nxt_we;
	logic        dsf_ff, nxt_dsf;
	logic        sc_ff, nxt_sc;
	logic [3:0]  part_ff, nxt_part;
	logic        half_s1_ff, half_s2_ff;
	logic        seq_start, seq_col_first, seq_done, seq_busy;
	logic        wr_en, rd_en, cmd_wr;
	logic [2:0]  wr_cmd;
	logic [8:0]  wr_col;
	logic [7:0]  stop_mask;
	logic        bad_split;

	////////////////////////////////////////////////////////////////////////
	// APB decode; always ready, no wait states
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign cmd_wr  = wr_en && (paddr == vram_ctl_pkg::CTRL_OFF);
	assign wr_cmd  = pwdata[vram_ctl_pkg::CMD_LSB +: 3];
	assign wr_col  = addr_reg_ff[vram_ctl_pkg::COL_LSB +: 9];

	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (paddr)
				vram_ctl_pkg::CTRL_OFF:  prdata = ctrl_ff;
				vram_ctl_pkg::ADDR_OFF:  prdata = addr_reg_ff;
				vram_ctl_pkg::SHIFT_OFF: prdata = {16'h0000, shift_ff};
				vram_ctl_pkg::STATUS_OFF: begin
					prdata[vram_ctl_pkg::BUSY_BIT]  = (st_ff != C_IDLE);
					prdata[vram_ctl_pkg::HALF_BIT]  = half_s2_ff;
					prdata[vram_ctl_pkg::STOPM_BIT] = stopm_ff;
					prdata[vram_ctl_pkg::FULLD_BIT] = fulld_ff;
					prdata[vram_ctl_pkg::ERR_BIT]   = err_ff;
					prdata[vram_ctl_pkg::INITD_BIT] = initd_ff;
				end
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// Stop points are locations whose low bits under the partition length are all ones
	always_comb begin
		unique case (part_ff)
			vram_ctl_pkg::PART16:  stop_mask = 8'h0F;
			vram_ctl_pkg::PART32:  stop_mask = 8'h1F;
			vram_ctl_pkg::PART64:  stop_mask = 8'h3F;
			default:               stop_mask = 8'h7F;
		endcase
	end

	// Illegal split start points are refused rather than issued
	always_comb begin
		bad_split = !fulld_ff;
		if (wr_col[6:0] == 7'h7F) begin
			bad_split = 1'b1;
		end
		if (stopm_ff && ((wr_col[7:0] & stop_mask) == stop_mask)) begin
			bad_split = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Half indicator from the device is a pin: two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_s1_ff <= 1'b0;
			half_s2_ff <= 1'b0;
		end else begin
			half_s1_ff <= half_indicator_out;
			half_s2_ff <= half_s1_ff;
		end
	end

	strobe_seq #(
		.PHASE           (vram_ctl_pkg::PHASE_CYC)
	) u_seq (
		.pclk            (pclk),
		.presetn         (presetn),
		.start           (seq_start),
		.col_first       (seq_col_first),
		.done            (seq_done),
		.busy            (seq_busy),
		.row_strobe_n    (row_strobe_n),
		.column_strobe_n (column_strobe_n)
	);

	////////////////////////////////////////////////////////////////////////
	// Main sequencer
	always_comb begin
		nxt_st        = st_ff;
		nxt_ctrl      = ctrl_ff;
		nxt_addr_reg  = addr_reg_ff;
		nxt_shift     = shift_ff;
		nxt_wait      = wait_ff;
		nxt_stopm     = stopm_ff;
		nxt_fulld     = fulld_ff;
		nxt_err       = err_ff;
		nxt_initd     = initd_ff;
		nxt_cmd       = cmd_ff;
		nxt_addr      = addr_ff;
		nxt_trg       = trg_ff;
		nxt_we        = we_ff;
		nxt_dsf       = dsf_ff;
		nxt_sc        = sc_ff;
		nxt_part      = part_ff;
		seq_start     = 1'b0;
		seq_col_first = 1'b0;
		if (wr_en && paddr == vram_ctl_pkg::ADDR_OFF) begin
			nxt_addr_reg = pwdata;
		end
		if (wr_en && paddr == vram_ctl_pkg::SHIFT_OFF) begin
			nxt_shift = pwdata[15:0];
		end
		if (cmd_wr) begin
			nxt_ctrl = pwdata;
		end
		unique case (st_ff)
			C_PWR: begin
				if (wait_ff == 16'(PWRUP_CYCLES)) begin
					nxt_wait = 16'h0000;
					nxt_st   = C_INITROW;
				end else begin
					nxt_wait = wait_ff + 16'h0001;
				end
			end
			C_INITROW: begin
				// Plain row cycles with write strobe high and transfer deselected
				if (!seq_busy && !seq_done) begin
					seq_start = 1'b1;
				end
				if (seq_done) begin
					if (wait_ff == 16'(vram_ctl_pkg::INIT_ROWS - 1)) begin
						nxt_wait = 16'h0000;
						nxt_trg  = 1'b0;
						nxt_dsf  = 1'b0;
						nxt_addr = 9'h000;
						nxt_st   = C_INITXF;
					end else begin
						nxt_wait = wait_ff + 16'h0001;
					end
				end
			end
			C_INITXF: begin
				if (!seq_busy && !seq_done) begin
					seq_start = 1'b1;
				end
				if (seq_done) begin
					nxt_trg   = 1'b1;
					nxt_fulld = 1'b1;
					nxt_shift = 16'(vram_ctl_pkg::INIT_SHIFTS);
					nxt_st    = C_SC;
				end
			end
			C_IDLE: begin
				if (cmd_wr) begin
					nxt_cmd = wr_cmd;
					unique case (wr_cmd)
						vram_ctl_pkg::CMD_FULL: begin
							nxt_trg  = 1'b0;
							nxt_dsf  = 1'b0;
							nxt_addr = addr_reg_ff[8:0];
							nxt_st   = C_CYC;
						end
						vram_ctl_pkg::CMD_SPLIT: begin
							if (bad_split) begin
								nxt_err = 1'b1;
							end else begin
								nxt_trg  = 1'b0;
								nxt_dsf  = 1'b1;
								nxt_addr = addr_reg_ff[8:0];
								nxt_st   = C_CYC;
							end
						end
						vram_ctl_pkg::CMD_STOPS: begin
							nxt_we   = 1'b0;
							nxt_dsf  = 1'b1;
							nxt_addr = {1'b0, addr_reg_ff[7:4], 4'h0};
							nxt_part = addr_reg_ff[7:4];
							nxt_st   = C_CYC;
						end
						vram_ctl_pkg::CMD_CBR: begin
							nxt_dsf = 1'b0;
							nxt_st  = C_CYC;
						end
						vram_ctl_pkg::CMD_SHIFT: begin
							if (shift_ff != 16'h0000) begin
								nxt_st = C_SC;
							end
						end
						vram_ctl_pkg::CMD_INIT: begin
							nxt_wait  = 16'h0000;
							nxt_initd = 1'b0;
							nxt_st    = C_PWR;
						end
						// Enable-only update, nothing to run
						vram_ctl_pkg::CMD_NONE: nxt_err = err_ff;
						default: nxt_err = 1'b1;
					endcase
				end
			end
			C_CYC: begin
				// Row address is on addr before the row fall; column after it
				if (!seq_busy && !seq_done) begin
					seq_start     = 1'b1;
					seq_col_first = (cmd_ff == vram_ctl_pkg::CMD_STOPS) ||
						(cmd_ff == vram_ctl_pkg::CMD_CBR);
				end
				if (seq_busy && !row_strobe_n && column_strobe_n) begin
					nxt_addr = wr_col;
					if (stopm_ff) begin
						nxt_addr = {wr_col[7], wr_col[8], wr_col[6:0]};
					end
				end
				if (seq_done) begin
					nxt_trg = 1'b1;
					nxt_we  = 1'b1;
					nxt_dsf = 1'b0;
					nxt_st  = C_IDLE;
					if (cmd_ff == vram_ctl_pkg::CMD_FULL) begin
						nxt_fulld = 1'b1;
					end
					if (cmd_ff == vram_ctl_pkg::CMD_STOPS) begin
						nxt_stopm = 1'b1;
					end
					if (cmd_ff == vram_ctl_pkg::CMD_CBR) begin
						nxt_stopm = 1'b0;
					end
				end
			end
			C_SC: begin
				// Serial clocks only outside transfer cycles
				if (wait_ff == 16'(vram_ctl_pkg::SC_HALF_CYC - 1)) begin
					nxt_wait = 16'h0000;
					nxt_sc   = ~sc_ff;
					if (sc_ff) begin
						nxt_shift = shift_ff - 16'h0001;
						if (shift_ff == 16'h0001) begin
							nxt_st    = C_IDLE;
							nxt_initd = 1'b1;
						end
					end
				end else begin
					nxt_wait = wait_ff + 16'h0001;
				end
			end
			default: nxt_st = C_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff       <= C_PWR;
			ctrl_ff     <= vram_ctl_pkg::CTRL_RST;
			addr_reg_ff <= 32'h0000_0000;
			shift_ff    <= 16'h0000;
			wait_ff     <= 16'h0000;
			stopm_ff    <= 1'b0;
			fulld_ff    <= 1'b0;
			err_ff      <= 1'b0;
			initd_ff    <= 1'b0;
			cmd_ff      <= vram_ctl_pkg::CMD_NONE;
			addr_ff     <= 9'h000;
			trg_ff      <= 1'b1;
			we_ff       <= 1'b1;
			dsf_ff      <= 1'b0;
			sc_ff       <= 1'b0;
			part_ff     <= vram_ctl_pkg::PART128;
		end else begin
			st_ff       <= nxt_st;
			ctrl_ff     <= nxt_ctrl;
			addr_reg_ff <= nxt_addr_reg;
			shift_ff    <= nxt_shift;
			wait_ff     <= nxt_wait;
			stopm_ff    <= nxt_stopm;
			fulld_ff    <= nxt_fulld;
			err_ff      <= nxt_err;
			initd_ff    <= nxt_initd;
			cmd_ff      <= nxt_cmd;
			addr_ff     <= nxt_addr;
			trg_ff      <= nxt_trg;
			we_ff       <= nxt_we;
			dsf_ff      <= nxt_dsf;
			sc_ff       <= nxt_sc;
			part_ff     <= nxt_part;
		end
	end

	assign addr                    = addr_ff;
	assign write_strobe_n          = we_ff;
	assign transfer_select_n       = trg_ff;
	assign special_function_select = dsf_ff;
	assign serial_shift_clock      = sc_ff;
	assign serial_output_enable_n  = ctrl_ff[vram_ctl_pkg::OE_BIT];

	////////////////////////////////////////////////////////////////////////
	xfer_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(row_strobe_n) && !transfer_select_n |-> write_strobe_n)
		else $error("transfer with write strobe low");
	split_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(row_strobe_n) && !transfer_select_n && special_function_select |-> fulld_ff)
		else $error("split before full transfer");
	split_tap_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_ff == C_CYC && cmd_ff == vram_ctl_pkg::CMD_SPLIT && $fell(column_strobe_n)
		|-> addr_ff[6:0] != 7'h7F)
		else $error("split start at half top");
	no_sc_xfer_a: assert property (@(posedge pclk) disable iff (!presetn)
		!row_strobe_n && !transfer_select_n |-> $stable(serial_shift_clock))
		else $error("serial clock during transfer");
	stops_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(row_strobe_n) && !write_strobe_n |-> !column_strobe_n && special_function_select)
		else $error("bad stop-point set cycle");
	pwr_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_ff == C_PWR |-> row_strobe_n && serial_shift_clock == 1'b0)
		else $error("activity during power-up wait");
	cbr_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_ff == C_CYC && cmd_ff == vram_ctl_pkg::CMD_CBR && seq_done |=> !stopm_ff)
		else $error("stop mode survives refresh");
	swap_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_ff == C_CYC && stopm_ff && $fell(column_strobe_n) && cmd_ff != vram_ctl_pkg::CMD_CBR
		&& cmd_ff != vram_ctl_pkg::CMD_STOPS |-> addr_ff[8] == wr_col[7])
		else $error("column bits not swapped");

	full_c: cover property (@(posedge pclk) disable iff (!presetn)
		st_ff == C_CYC && cmd_ff == vram_ctl_pkg::CMD_FULL && seq_done);
	split_c: cover property (@(posedge pclk) disable iff (!presetn)
		st_ff == C_CYC && cmd_ff == vram_ctl_pkg::CMD_SPLIT && seq_done);
	stops_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(stopm_ff));
	init_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(initd_ff));

endmodule
`default_nettype wire

// ===== core/vram_ctl_pkg.sv
// Behaviour
// - Transfer request: transfer select low, write strobe high at row strobe fall.
// - Split transfer: special function high, transfer select low at row fall; 9-bit row.
// - Controller never uses 127 or 255 as split start location.
// - In stop-point mode controller never starts a split at a stop point.
// - Controller does a full transfer before the first split transfer.
// - Stop-point set: column low, write low, special high at row fall, after init.
// - Power-up: wait 200 us, eight row cycles, full transfer, two serial clocks.
package vram_ctl_pkg;

	// APB register offsets
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] ADDR_OFF   = 8'h04;
	localparam logic [7:0] STATUS_OFF = 8'h08;
	localparam logic [7:0] SHIFT_OFF  = 8'h0C;

	// Command codes in the control register
	localparam logic [2:0] CMD_NONE  = 3'h0;
	localparam logic [2:0] CMD_FULL  = 3'h1;
	localparam logic [2:0] CMD_SPLIT = 3'h2;
	localparam logic [2:0] CMD_STOPS = 3'h3;
	localparam logic [2:0] CMD_CBR   = 3'h4;
	localparam logic [2:0] CMD_SHIFT = 3'h5;
	localparam logic [2:0] CMD_INIT  = 3'h6;

	// Field positions
	localparam int CMD_LSB   = 0;
	localparam int OE_BIT    = 4;
	localparam int ROW_LSB   = 0;
	localparam int COL_LSB   = 16;
	localparam int PART_LSB  = 28;

	// Status bits
	localparam int BUSY_BIT  = 0;
	localparam int HALF_BIT  = 1;
	localparam int STOPM_BIT = 2;
	localparam int FULLD_BIT = 3;
	localparam int ERR_BIT   = 4;
	localparam int INITD_BIT = 5;

	// Partition codes for row bits 7..4
	localparam logic [3:0] PART16  = 4'h0;
	localparam logic [3:0] PART32  = 4'h1;
	localparam logic [3:0] PART64  = 4'h3;
	localparam logic [3:0] PART128 = 4'h7;

	// Timing
	localparam int CLK_MHZ      = 40;
	localparam int PWRUP_US     = 200;
	localparam int PWRUP_CYC    = PWRUP_US * CLK_MHZ;
	localparam int INIT_ROWS    = 8;
	localparam int INIT_SHIFTS  = 2;
	localparam int PHASE_CYC    = 4;
	localparam int SC_HALF_CYC  = 4;

	localparam logic [31:0] CTRL_RST = 32'h0000_0010;

endpackage

// ===== core/strobe_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Drives one strobe cycle: row fall, column fall (before the row fall when col_first), release.
module strobe_seq #(
	parameter int PHASE = 4
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Request
	input  wire logic       start,
	input  wire logic       col_first,
	output logic            done,
	output logic            busy,
	// Strobes
	output logic            row_strobe_n,
	output logic            column_strobe_n
);
	typedef enum logic [2:0] {S_IDLE, S_PRE, S_ROW, S_COL, S_END} seq_e;
	seq_e       st_ff, nxt_st;
	logic [7:0] cnt_ff, nxt_cnt;
	logic       col_first_ff, nxt_col_first;
	logic       ras_ff, nxt_ras;
	logic       cas_ff, nxt_cas;

	always_comb begin
		nxt_st        = st_ff;
		nxt_cnt       = cnt_ff;
		nxt_col_first = col_first_ff;
		nxt_ras       = ras_ff;
		nxt_cas       = cas_ff;
		done          = 1'b0;
		unique case (st_ff)
			S_IDLE: begin
				if (start) begin
					nxt_col_first = col_first;
					nxt_cas       = ~col_first;
					nxt_cnt       = 8'(PHASE);
					nxt_st        = S_PRE;
				end
			end
			S_PRE: begin
				if (cnt_ff == 8'h00) begin
					nxt_ras = 1'b0;
					nxt_cnt = 8'(PHASE);
					nxt_st  = S_ROW;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			S_ROW: begin
				if (cnt_ff == 8'h00) begin
					nxt_cas = 1'b0;
					nxt_cnt = 8'(PHASE);
					nxt_st  = S_COL;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			S_COL: begin
				if (cnt_ff == 8'h00) begin
					nxt_ras = 1'b1;
					nxt_cas = 1'b1;
					nxt_cnt = 8'(PHASE);
					nxt_st  = S_END;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			S_END: begin
				if (cnt_ff == 8'h00) begin
					done   = 1'b1;
					nxt_st = S_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff        <= S_IDLE;
			cnt_ff       <= 8'h00;
			col_first_ff <= 1'b0;
			ras_ff       <= 1'b1;
			cas_ff       <= 1'b1;
		end else begin
			st_ff        <= nxt_st;
			cnt_ff       <= nxt_cnt;
			col_first_ff <= nxt_col_first;
			ras_ff       <= nxt_ras;
			cas_ff       <= nxt_cas;
		end
	end

	assign busy            = (st_ff != S_IDLE);
	assign row_strobe_n    = ras_ff;
	assign column_strobe_n = cas_ff;

	strobe_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(row_strobe_n) |-> ##(PHASE+1) !column_strobe_n || col_first_ff)
		else $error("column strobe late after row fall");

endmodule
`default_nettype wire

// ===== testbench/vram_serial_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial half of the memory, driven only by pin edges
module vram_serial_model (
	// Strobes and address
	input  wire logic       row_strobe_n,
	input  wire logic       column_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic       transfer_select_n,
	input  wire logic       special_function_select,
	input  wire logic [8:0] addr,
	// Serial port
	input  wire logic       serial_shift_clock,
	output logic            half_indicator_out
);
	logic [7:0] ptr        = 8'h00;
	logic [7:0] pend_tap   = 8'h00;
	logic [8:0] row_l      = 9'h000;
	logic [8:0] col_l      = 9'h000;
	logic [3:0] part       = 4'h7;
	logic [1:0] kind       = 2'd0;
	logic       split_mode = 1'b0;
	logic       stop_mode  = 1'b0;
	logic       pend       = 1'b0;
	int         n_row      = 0;
	int         n_xfer     = 0;
	int         sc_count   = 0;
	int         sc_in_xfer = 0;
	time        t_first    = 0;
	logic [6:0] mask;

	////////////////////////////////////////////////////////////////////////////
	// Plain split mode stops only at the top of a half
	assign mask = stop_mode ? {part[2:0], 4'hF} : 7'h7F;
	assign half_indicator_out = ptr[7];

	always @(negedge row_strobe_n) begin
		n_row++;
		if (n_row == 1) t_first = $time;
		row_l = addr;
		kind = 2'd0;
		if (!column_strobe_n) begin
			if (!write_strobe_n && special_function_select) begin
				stop_mode = 1'b1;
				part = addr[7:4];
			end else begin
				stop_mode = 1'b0;
			end
		end else if (!transfer_select_n && write_strobe_n) begin
			kind = special_function_select ? 2'd2 : 2'd1;
		end
	end

	always @(negedge column_strobe_n) begin
		if (!row_strobe_n && kind != 2'd0) begin
			col_l = stop_mode ? {addr[7], addr[8], addr[6:0]} : addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transfer lands when the row strobe closes the cycle
	always @(posedge row_strobe_n) begin
		if (kind == 2'd1) begin
			ptr = col_l[7:0];
			split_mode = 1'b0;
			pend = 1'b0;
		end else if (kind == 2'd2) begin
			pend_tap = {~ptr[7], col_l[6:0]};
			split_mode = 1'b1;
			pend = 1'b1;
		end
		if (kind != 2'd0) n_xfer++;
		kind = 2'd0;
	end

	always @(posedge serial_shift_clock) begin
		sc_count++;
		if (kind != 2'd0) sc_in_xfer++;
		if (split_mode && (ptr[6:0] & mask) == mask) begin
			ptr = pend ? pend_tap : {~ptr[7], 7'h00};
			pend = 1'b0;
		end else begin
			ptr = ptr + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/test_vram_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module test_vram_ctl;
	localparam int PWR = 20;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        serial_output_enable_n;
	logic        row_strobe_n;
	logic        column_strobe_n;
	logic        write_strobe_n;
	logic        transfer_select_n;
	logic        special_function_select;
	logic [8:0]  addr;
	logic        serial_shift_clock;
	logic        half_indicator_out;
	int          n_errors    = 0;
	int          check_count = 0;

	vram_ctl #(.PWRUP_CYCLES(PWR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
		.transfer_select_n(transfer_select_n),
		.special_function_select(special_function_select), .addr(addr),
		.serial_shift_clock(serial_shift_clock),
		.serial_output_enable_n(serial_output_enable_n),
		.half_indicator_out(half_indicator_out));

	vram_serial_model mem (.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
		.write_strobe_n(write_strobe_n), .transfer_select_n(transfer_select_n),
		.special_function_select(special_function_select), .addr(addr),
		.serial_shift_clock(serial_shift_clock), .half_indicator_out(half_indicator_out));

	always #12.5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 100);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			end_sim();
		end
	endtask

	// Polls a status bit; a hang ends the run
	task automatic wait_bit(input int b, input logic v);
		logic [31:0] s;
		int i;
		repeat (2) @(posedge pclk);
		for (i = 0; i < 3000; i++) begin
			apb(1'b0, vram_ctl_pkg::STATUS_OFF, 32'h0, s);
			if (s[b] === v) break;
		end
		if (s[b] !== v) begin
			n_errors++;
			end_sim();
		end
	endtask

	task automatic stat(input int b, input logic v);
		logic [31:0] s;
		apb(1'b0, vram_ctl_pkg::STATUS_OFF, 32'h0, s);
		check(32'(s[b]), 32'(v));
	endtask

	// Outputs stay disabled so counting must not depend on the enable
	task automatic run(input logic [2:0] c, input logic [31:0] a, input logic [31:0] n);
		logic [31:0] q;
		apb(1'b1, vram_ctl_pkg::ADDR_OFF, a, q);
		apb(1'b1, vram_ctl_pkg::SHIFT_OFF, n, q);
		apb(1'b1, vram_ctl_pkg::CTRL_OFF, {27'h0, 1'b1, 1'b0, c}, q);
		wait_bit(vram_ctl_pkg::BUSY_BIT, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		time         t_rel;
		int          x;
		repeat (3) @(posedge pclk);
		check({31'h0, row_strobe_n & column_strobe_n & transfer_select_n}, 32'h1);
		check({31'h0, serial_output_enable_n}, 32'h1);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_rel = $time;
		apb(1'b0, vram_ctl_pkg::CTRL_OFF, 32'h0, q);
		check(q, vram_ctl_pkg::CTRL_RST);
		wait_bit(vram_ctl_pkg::INITD_BIT, 1'b1);
		check(32'(mem.n_row), 32'd9);
		check(32'(mem.sc_count), 32'd2);
		check(32'(mem.t_first - t_rel >= PWR * 25), 32'h1);
		check(32'(mem.ptr), 32'h2);
		run(vram_ctl_pkg::CMD_FULL, 32'h0180_01A5, 32'h0);
		check(32'(mem.row_l), 32'h1A5);
		check(32'(mem.col_l), 32'h180);
		stat(vram_ctl_pkg::HALF_BIT, 1'b1);
		run(vram_ctl_pkg::CMD_SHIFT, 32'h0, 32'd128);
		check(32'(mem.sc_count), 32'd130);
		check(32'(mem.ptr), 32'h0);
		stat(vram_ctl_pkg::HALF_BIT, 1'b0);
		run(vram_ctl_pkg::CMD_FULL, 32'h0, 32'h0);
		run(vram_ctl_pkg::CMD_SPLIT, 32'h0010_0033, 32'h0);
		check(32'(mem.pend_tap), 32'h90);
		run(vram_ctl_pkg::CMD_SHIFT, 32'h0, 32'd128);
		check(32'(mem.ptr), 32'h90);
		stat(vram_ctl_pkg::HALF_BIT, 1'b1);
		run(vram_ctl_pkg::CMD_SHIFT, 32'h0, 32'd112);
		check(32'(mem.ptr), 32'h0);
		x = mem.n_xfer;
		stat(vram_ctl_pkg::ERR_BIT, 1'b0);
		run(vram_ctl_pkg::CMD_SPLIT, 32'h007F_0000, 32'h0);
		check(32'(mem.n_xfer), 32'(x));
		stat(vram_ctl_pkg::ERR_BIT, 1'b1);
		run(vram_ctl_pkg::CMD_STOPS, {24'h0, vram_ctl_pkg::PART16, 4'h0}, 32'h0);
		stat(vram_ctl_pkg::STOPM_BIT, 1'b1);
		check(32'(mem.part), 32'h0);
		run(vram_ctl_pkg::CMD_SPLIT, 32'h000F_0000, 32'h0);
		check(32'(mem.n_xfer), 32'(x));
		run(vram_ctl_pkg::CMD_SPLIT, 32'h0110_0000, 32'h0);
		check(32'(mem.col_l), 32'h110);
		check(32'(addr), 32'h090);
		run(vram_ctl_pkg::CMD_SHIFT, 32'h0, 32'd16);
		check(32'(mem.ptr), 32'h90);
		run(vram_ctl_pkg::CMD_CBR, 32'h0, 32'h0);
		stat(vram_ctl_pkg::STOPM_BIT, 1'b0);
		check(32'(mem.stop_mode), 32'h0);
		check(32'(mem.sc_in_xfer), 32'h0);
		x = mem.n_row;
		run(vram_ctl_pkg::CMD_INIT, 32'h0, 32'h0);
		check(32'(mem.n_row - x), 32'd9);
		check(32'(mem.ptr), 32'h2);
		stat(vram_ctl_pkg::INITD_BIT, 1'b1);
		apb(1'b1, vram_ctl_pkg::CTRL_OFF, {27'h0, 1'b0, 1'b0, vram_ctl_pkg::CMD_NONE}, q);
		// Enable is registered at the access edge
		@(posedge pclk);
		check({31'h0, serial_output_enable_n}, 32'h0);
		check({31'h0, pslverr}, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
